// File: logic/hpp_port_power.sv
// hub downstream port power, overcurrent sense, straps and upstream detect
// assumes all pin inputs are synchronous to core_clk_in; pads resolve oe
`timescale 1ns/10ps

module hpp_port_power
  import hpp_pkg::*;
#(
  parameter int NPORT       = NUM_PORTS,
  parameter int FILTER_CYC  = DETECT_FILTER_CYCLES
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  // downstream port pins (bit 3 is also the shared power pin)
  input  wire logic [NPORT-1:0] port_power_sense_pins_in,
  output logic      [NPORT-1:0] port_power_sense_pins_out,
  output logic      [NPORT-1:0] port_power_sense_pins_oe_out,
  // disable straps on the downstream data pins
  input  wire logic [NPORT-1:0] port_dplus_disable_strap_in,
  input  wire logic [NPORT-1:0] port_dminus_disable_strap_in,
  // firmware side controls
  input  wire logic [NPORT-1:0] port_power_req_in,
  input  wire logic [NPORT-1:0] port_pin_is_input_in,
  input  wire logic [NPORT-1:0] overcurrent_clear_in,
  // port status
  output logic      [NPORT-1:0] port_power_on_out,
  output logic      [NPORT-1:0] port_disabled_out,
  output logic      [NPORT-1:0] overcurrent_flag_out,
  output logic      [NPORT-1:0] overcurrent_event_out,
  output logic                  gang_mode_out,
  output logic                  straps_valid_out,
  // upstream detect pin, also general io 16
  input  wire logic             upstream_power_detect_in,
  output logic                  general_io_16_out,
  output logic                  general_io_16_oe_out,
  input  wire logic             general_io_16_mode_in,
  input  wire logic             general_io_16_drive_in,
  input  wire logic             general_io_16_drive_en_in,
  output logic                  general_io_16_value_out,
  output logic                  upstream_connected_out,
  output logic                  upstream_reconnect_out
);

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic [2*NPORT:0]  strap_q;
  logic              strap_valid;
  logic [NPORT-1:0]  dplus_dis;
  logic [NPORT-1:0]  dminus_dis;
  logic              gang_mode;

  // gang strap is read on the shared pin while it is still released
  hpp_strap_latch #(
    .WIDTH (2*NPORT+1)
  ) u_strap (
    .clk_in      (core_clk_in),
    .rst_n_in    (rst_n_in),
    .strap_in    ({port_power_sense_pins_in[GANG_PIN_IDX],
                   port_dminus_disable_strap_in,
                   port_dplus_disable_strap_in}),
    .strap_q_out (strap_q),
    .valid_out   (strap_valid)
  );

  assign dplus_dis  = strap_q[STRAP_DPLUS_LSB +: NPORT];
  assign dminus_dis = strap_q[STRAP_DMINUS_LSB +: NPORT];
  assign gang_mode  = strap_valid & strap_q[STRAP_GANG_POS];

  // ----------------------------------------------------------------
  // per-port combinational decisions
  // ----------------------------------------------------------------
  logic [NPORT-1:0] port_dis;
  logic [NPORT-1:0] sense_hit;
  logic [NPORT-1:0] oc_hit;
  logic [NPORT-1:0] oc_flag_d;
  logic [NPORT-1:0] power_d;
  logic [NPORT-1:0] pin_out_d;
  logic [NPORT-1:0] pin_oe_d;
  logic             gang_req;
  logic             gang_oc;
  logic [NPORT-1:0] oc_flag_q;
  logic [NPORT-1:0] oc_hit_q;

  // shared request: any enabled port asks for power
  assign gang_req = |(port_power_req_in & ~port_dis);
  // shared overcurrent: shared pin used as input and asserted high
  assign gang_oc  = sense_hit[GANG_PIN_IDX];

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      // port off only when both data-line straps ask for it
      assign port_dis[gi] = strap_valid & dplus_dis[gi] & dminus_dis[gi];

      // pin read as input: high level reports overcurrent
      assign sense_hit[gi] = strap_valid & port_pin_is_input_in[gi]
                             & port_power_sense_pins_in[gi];

      // gang mode maps the one shared sense onto every live port
      assign oc_hit[gi] = ~port_dis[gi] & (gang_mode ? gang_oc : sense_hit[gi]);

      // set wins over a clear in the same cycle
      assign oc_flag_d[gi] = oc_hit[gi] | (oc_flag_q[gi] & ~overcurrent_clear_in[gi]);

      // power only for live, requested, fault-free ports
      assign power_d[gi] = strap_valid & ~port_dis[gi] & ~oc_flag_d[gi]
                           & (gang_mode ? gang_req : port_power_req_in[gi]);

      // pin drive: own port in normal mode, only the shared pin in gang mode
      if (gi == GANG_PIN_IDX) begin : g_shared
        assign pin_oe_d[gi]  = strap_valid & ~port_pin_is_input_in[gi]
                               & (gang_mode | ~port_dis[gi]);
        assign pin_out_d[gi] = pin_oe_d[gi] &
                               (gang_mode ? (gang_req & ~(|oc_flag_d)) : power_d[gi]);
      end else begin : g_plain
        assign pin_oe_d[gi]  = strap_valid & ~gang_mode & ~port_dis[gi]
                               & ~port_pin_is_input_in[gi];
        assign pin_out_d[gi] = pin_oe_d[gi] & power_d[gi];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // overcurrent flags and events
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_flag_q             <= PORT_RST_VAL;
      oc_hit_q              <= PORT_RST_VAL;
      overcurrent_event_out <= PORT_RST_VAL;
    end else begin
      oc_flag_q             <= oc_flag_d;
      oc_hit_q              <= oc_hit;
      overcurrent_event_out <= oc_hit & ~oc_hit_q;      // one pulse per onset
    end
  end

  assign overcurrent_flag_out = oc_flag_q;

  // ----------------------------------------------------------------
  // port power and pin drive registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_power_on_out            <= PORT_RST_VAL;
      port_power_sense_pins_out    <= PORT_RST_VAL;
      port_power_sense_pins_oe_out <= PORT_RST_VAL;   // released so straps read
    end else begin
      port_power_on_out            <= power_d;
      port_power_sense_pins_out    <= pin_out_d;
      port_power_sense_pins_oe_out <= pin_oe_d;
    end
  end

  // ----------------------------------------------------------------
  // strap status registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_disabled_out <= PORT_RST_VAL;
      gang_mode_out     <= 1'b0;
      straps_valid_out  <= 1'b0;
    end else begin
      port_disabled_out <= port_dis;
      gang_mode_out     <= gang_mode;
      straps_valid_out  <= strap_valid;
    end
  end

  // ----------------------------------------------------------------
  // detect pin as general io 16
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      general_io_16_out       <= 1'b0;
      general_io_16_oe_out    <= 1'b0;
      general_io_16_value_out <= 1'b0;
    end else begin
      general_io_16_oe_out    <= general_io_16_mode_in & general_io_16_drive_en_in;
      general_io_16_out       <= general_io_16_mode_in & general_io_16_drive_in;
      general_io_16_value_out <= upstream_power_detect_in;
    end
  end

  // ----------------------------------------------------------------
  // upstream detect filter
  // ----------------------------------------------------------------
  logic                    detect_raw;
  logic                    detect_filt_q;
  logic [FILTER_CNT_W-1:0] filt_cnt_q;

  // in general io use the upstream is taken as always powered
  assign detect_raw = general_io_16_mode_in | upstream_power_detect_in;

  // a new level must hold FILTER_CYC cycles before it is believed
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      detect_filt_q <= 1'b0;
      filt_cnt_q    <= FILTER_CNT_RST;
    end else if (detect_raw == detect_filt_q) begin
      filt_cnt_q    <= FILTER_CNT_RST;
    end else if (filt_cnt_q == FILTER_CNT_W'(FILTER_CYC - 1)) begin
      detect_filt_q <= detect_raw;
      filt_cnt_q    <= FILTER_CNT_RST;
    end else begin
      filt_cnt_q    <= filt_cnt_q + FILTER_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // upstream connection state
  // ----------------------------------------------------------------
  hpp_up_state_t up_state_q;
  hpp_up_state_t up_state_d;

  // loss of power detaches; return of power renegotiates, no reset
  always_comb begin
    up_state_d = up_state_q;
    case (up_state_q)
      HPP_UP_NO_POWER: begin
        if (detect_filt_q) begin
          up_state_d = HPP_UP_RENEGOTIATE;
        end
      end
      HPP_UP_RENEGOTIATE: begin
        up_state_d = detect_filt_q ? HPP_UP_CONNECTED : HPP_UP_NO_POWER;
      end
      HPP_UP_CONNECTED: begin
        if (!detect_filt_q) begin
          up_state_d = HPP_UP_NO_POWER;
        end
      end
      default: begin
        up_state_d = HPP_UP_NO_POWER;
      end
    endcase
  end

  // state register; outputs decode the next state, so they change on the same edge as it
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_state_q             <= HPP_UP_NO_POWER;
      upstream_connected_out <= 1'b0;
      upstream_reconnect_out <= 1'b0;
    end else begin
      up_state_q             <= up_state_d;
      upstream_connected_out <= (up_state_d == HPP_UP_CONNECTED);
      upstream_reconnect_out <= (up_state_d == HPP_UP_RENEGOTIATE);
    end
  end

endmodule

// File: logic/hpp_pkg.sv
// hub port power and strap logic: shared constants and types
// assumes a single 25 MHz core clock and no register bus

package hpp_pkg;

  // ----------------------------------------------------------------
  // port geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS     = 4;
  localparam int GANG_PIN_IDX  = 3;   // port 4 pin doubles as shared power pin
  localparam int GENERAL_IO_NUM = 16; // general io number of the detect pin

  // ----------------------------------------------------------------
  // strap vector layout: {gang, dminus[4:1], dplus[4:1]}
  // ----------------------------------------------------------------
  localparam int STRAP_DPLUS_LSB  = 0;
  localparam int STRAP_DMINUS_LSB = NUM_PORTS;
  localparam int STRAP_GANG_POS   = 2 * NUM_PORTS;
  localparam int STRAP_WIDTH      = 2 * NUM_PORTS + 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ       = 25_000_000;
  localparam int DETECT_FILTER_NS  = 160;   // detect level must hold this long
  localparam int DETECT_FILTER_CYCLES =
    (DETECT_FILTER_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000 < 1 ? 1 :
    (DETECT_FILTER_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int FILTER_CNT_W      = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_PORTS-1:0]   PORT_RST_VAL  = 4'h0;
  localparam logic [STRAP_WIDTH-1:0] STRAP_RST_VAL = 9'h000;
  localparam logic [FILTER_CNT_W-1:0] FILTER_CNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // upstream connection state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HPP_UP_NO_POWER    = 3'b001,
    HPP_UP_RENEGOTIATE = 3'b010,
    HPP_UP_CONNECTED   = 3'b100
  } hpp_up_state_t;

endpackage

// File: logic/hpp_strap_latch.sv
// strap capture: takes the strap levels once after each reset release
// assumes straps are stable around the reset release
`timescale 1ns/10ps

module hpp_strap_latch
  import hpp_pkg::*;
#(
  parameter int WIDTH = STRAP_WIDTH
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] strap_in,
  output logic      [WIDTH-1:0] strap_q_out,
  output logic                  valid_out
);

  // ----------------------------------------------------------------
  // capture at first edge after release (power-on or external reset)
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_q_out <= WIDTH'(STRAP_RST_VAL);
      valid_out   <= 1'b0;
    end else if (!valid_out) begin
      strap_q_out <= strap_in;
      valid_out   <= 1'b1;
    end
  end

endmodule

// File: test/hpp_switch_model.sv
// external port power switches and current monitors, four ports
// assumes the bench commands faults and strap resistor levels
`timescale 1ns/10ps

module hpp_switch_model
  import hpp_pkg::*;
(
  input  wire logic [NUM_PORTS-1:0] pin_drive_in,
  input  wire logic [NUM_PORTS-1:0] pin_oe_in,
  input  wire logic [NUM_PORTS-1:0] fault_cmd_in,
  input  wire logic [NUM_PORTS-1:0] strap_pull_in,
  output logic      [NUM_PORTS-1:0] pin_level_out,
  output logic      [NUM_PORTS-1:0] switch_on_out
);
  // switch closes only while the hub drives its pin high
  assign switch_on_out = pin_oe_in & pin_drive_in;
  // released pin: monitor drives fault high, else strap level
  assign pin_level_out = switch_on_out | (~pin_oe_in & (fault_cmd_in | strap_pull_in));
endmodule

// File: test/hpp_port_power_asserts.sv
// checker: power, fault, gang, detect and io16 relations at the ports
// assumes it is bound to hpp_port_power, one clock, async low reset
`timescale 1ns/10ps

module hpp_port_power_asserts
  import hpp_pkg::*;
#(
  parameter int FILTER_CYC = DETECT_FILTER_CYCLES
) (
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] port_power_sense_pins_in,
  input wire logic [3:0] port_power_sense_pins_out,
  input wire logic [3:0] port_power_sense_pins_oe_out,
  input wire logic [3:0] port_pin_is_input_in,
  input wire logic [3:0] port_power_on_out,
  input wire logic [3:0] port_disabled_out,
  input wire logic [3:0] overcurrent_flag_out,
  input wire logic [3:0] overcurrent_event_out,
  input wire logic       gang_mode_out,
  input wire logic       straps_valid_out,
  input wire logic       upstream_power_detect_in,
  input wire logic       general_io_16_mode_in,
  input wire logic       general_io_16_drive_in,
  input wire logic       general_io_16_drive_en_in,
  input wire logic       general_io_16_out,
  input wire logic       general_io_16_oe_out,
  input wire logic       upstream_connected_out,
  input wire logic       upstream_reconnect_out
);
  // ------------------------------------------------------------
  // helper logic and sequences
  // ------------------------------------------------------------
  logic [7:0] low_cnt_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // counts cycles with upstream power absent
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) low_cnt_q <= 8'h00;
    else if (general_io_16_mode_in || upstream_power_detect_in) low_cnt_q <= 8'h00;
    else if (low_cnt_q != 8'hFF) low_cnt_q <= low_cnt_q + 8'h01;
  end

  sequence s_reconnect;
    upstream_reconnect_out ##1 (!upstream_reconnect_out && upstream_connected_out);
  endsequence

  sequence s_io_drive;
    general_io_16_oe_out && (general_io_16_out == $past(general_io_16_drive_in));
  endsequence

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_disabled_stays_off: assert property ((port_disabled_out & (port_power_on_out | overcurrent_flag_out)) == 4'h0)
    else $error("disabled port powered or flagged");
  a_flag_cuts_power: assert property ((overcurrent_flag_out & port_power_on_out) == 4'h0)
    else $error("flagged port still powered");
  a_pin_needs_grant: assert property (!gang_mode_out |->
    (port_power_sense_pins_oe_out & port_power_sense_pins_out & ~port_power_on_out) == 4'h0)
    else $error("pin drives power without grant");
  a_fault_gives_event: assert property (!gang_mode_out && straps_valid_out && |(port_pin_is_input_in &
    port_power_sense_pins_in & ~port_disabled_out & ~overcurrent_flag_out) |=> |overcurrent_event_out)
    else $error("fault on sense pin gave no event");
  a_gang_sweeps_all: assert property (gang_mode_out && |overcurrent_flag_out |->
    overcurrent_flag_out == ~port_disabled_out)
    else $error("gang fault did not flag every live port");
  a_straps_hold: assert property (straps_valid_out && $past(straps_valid_out) |->
    $stable(port_disabled_out) && $stable(gang_mode_out))
    else $error("strap result changed without reset");
  a_reconnect_seq: assert property (upstream_reconnect_out |-> s_reconnect)
    else $error("reconnect pulse not followed by connection");
  a_detect_drop: assert property (low_cnt_q >= FILTER_CYC + 3 |-> !upstream_connected_out)
    else $error("connected without upstream power");
  a_io16_drive: assert property (general_io_16_mode_in && general_io_16_drive_en_in |=> s_io_drive)
    else $error("io16 drive not applied");
  a_io16_quiet: assert property (!general_io_16_mode_in |=> !general_io_16_oe_out)
    else $error("detect pin driven outside io mode");
endmodule

bind hpp_port_power hpp_port_power_asserts #(.FILTER_CYC(FILTER_CYC)) hpp_port_power_asserts_inst (.*);

// File: test/hpp_port_power_tb_top.sv
// bench: straps, port power, faults, gang mode, detect toggles, io16
// assumes the switch model on the port pins and the bound checker
`timescale 1ns/10ps

module hpp_port_power_tb_top;
  import hpp_pkg::*;
  localparam int FC = 2;
  logic       core_clk_in, rst_n_in, gang, sv, det, io_out, io_oe, io_mode, io_drv, io_en, io_val;
  logic       conn, reconn;
  logic [3:0] lvl, pout, poe, dp, dm, req, is_in, clr, oc, pull, pwr, dis, flag, evt, sw, e_dis;
  int         mismatches, tests_run, seed, hits;
  int         m_flag[4];     // model: held overcurrent flag per port
  logic [3:0] exp_q[$];      // model: queued expected event words
  wire logic  pin16 = io_oe ? io_out : det;

  hpp_port_power #(.FILTER_CYC(FC)) hpp_port_power_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .port_power_sense_pins_in(lvl),
    .port_power_sense_pins_out(pout), .port_power_sense_pins_oe_out(poe),
    .port_dplus_disable_strap_in(dp), .port_dminus_disable_strap_in(dm), .port_power_req_in(req),
    .port_pin_is_input_in(is_in), .overcurrent_clear_in(clr), .port_power_on_out(pwr),
    .port_disabled_out(dis), .overcurrent_flag_out(flag), .overcurrent_event_out(evt),
    .gang_mode_out(gang), .straps_valid_out(sv), .upstream_power_detect_in(pin16),
    .general_io_16_out(io_out), .general_io_16_oe_out(io_oe), .general_io_16_mode_in(io_mode),
    .general_io_16_drive_in(io_drv), .general_io_16_drive_en_in(io_en),
    .general_io_16_value_out(io_val), .upstream_connected_out(conn), .upstream_reconnect_out(reconn));

  hpp_switch_model hpp_switch_model_inst (
    .pin_drive_in(pout), .pin_oe_in(poe), .fault_cmd_in(oc), .strap_pull_in(pull),
    .pin_level_out(lvl), .switch_on_out(sw));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] want);
    tests_run++;
    if (seen !== want) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // behavioural model: power follows request, live straps and no held flag
  function automatic logic [3:0] model_power(input logic [3:0] r);
    logic [3:0] p;
    p = 4'h0;
    for (int j = 0; j < 4; j++) begin
      p[j] = r[j] & ~e_dis[j] & (m_flag[j] == 0);
    end
    return p;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  // reset with fresh random straps, port 4 always live
  task automatic do_reset(input logic strap_gang);
    rst_n_in = 1'b0;
    pull = {strap_gang, 3'h0};
    dp = 4'($random(seed));
    dm = 4'($random(seed)) & 4'h7;
    e_dis = dp & dm;
    tick(3);
    rst_n_in = 1'b1;
    tick(2);
    pull = 4'h0;
    check("disabled", dis, e_dis);
    check("gang", {3'h0, gang}, {3'h0, strap_gang});
    check("valid", {3'h0, sv}, 4'h1);
  endtask

  // ------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  // tests take about 70 cycles; 2000 cycles leaves a wide margin
  initial begin
    #80000;
    mismatches++;
    conclude();
  end

  initial begin
    seed = 20641;
    mismatches = 0;
    tests_run = 0;
    {det, io_mode, io_drv, io_en} = 4'h0;
    {req, is_in, clr, oc} = 16'h0000;
    do_reset(1'b0);
    req = 4'hF;
    tick(2);
    check("power_on", pwr, model_power(req));
    check("pin_drive", pout & poe, ~e_dis);
    check("switch", sw, ~e_dis);
    // one fault per port, then clear
    for (int i = 0; i < 4; i++) begin
      {is_in[i], oc[i]} = 2'h3;
      m_flag[i] = e_dis[i] ? 0 : 1;
      exp_q.push_back(~e_dis & (4'h1 << i));
      tick(1);
      check("event", evt, exp_q.pop_front());
      tick(1);
      check("flag", flag, ~e_dis & (4'h1 << i));
      check("power_cut", pwr | sw, model_power(req));
      // clear while the fault still stands: the set must win
      clr[i] = 1'b1;
      tick(1);
      check("set_wins", flag, ~e_dis & (4'h1 << i));
      {oc[i], is_in[i]} = 2'h0;
      m_flag[i] = 0;
      tick(1);
      clr[i] = 1'b0;
      tick(1);
      check("restored", pwr, model_power(req));
    end
    // external reset again, gang strap high
    do_reset(1'b1);
    req = 4'h8 | 4'($random(seed));
    tick(2);
    check("gang_pin", pout & poe, 4'h8);
    {is_in[3], oc[3]} = 2'h3;
    tick(2);
    check("gang_flag", flag, ~e_dis);
    check("gang_power", sw | pwr, 4'h0);
    {oc, is_in, clr} = 12'h00F;
    tick(1);
    clr = 4'h0;
    // short glitch, then two full toggles of the detect pin
    for (int k = 0; k < 3; k++) begin
      det = 1'b1;
      hits = 0;
      repeat (k == 0 ? 1 : FC + 4) begin
        tick(1);
        if (reconn === 1'b1) hits++;
      end
      check("connected", {3'h0, conn}, {3'h0, k != 0});
      det = 1'b0;
      repeat (FC + 3) begin
        tick(1);
        if (reconn === 1'b1) hits++;
      end
      check("reconnect", hits[3:0], (k != 0) ? 4'h1 : 4'h0);
      check("dropped", {3'h0, conn}, 4'h0);
    end
    // detect pin as general io 16
    {io_mode, io_en} = 2'h3;
    io_drv = 1'($random(seed));
    tick(2);
    check("io_back", {2'h0, io_oe, io_val}, {2'h0, 1'b1, io_drv});
    io_en = 1'b0;
    det = ~io_drv;
    tick(FC + 3);
    check("io_float", {2'h0, io_oe, io_val}, {2'h0, 1'b0, ~io_drv});
    check("io_power", {3'h0, conn}, 4'h1);
    conclude();
  end
endmodule
